// *** pkg/sapsq_pkg.sv ***
// Shared types and constants of the converter sequencer and byte readout.
// Assumes a single 125 MHz system clock; all strobe pins arrive asynchronous.
package sapsq_pkg;
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned CONV_MAX_NS    = 4700;
	// Longest time rounds down to whole cycles
	localparam int unsigned CONV_CYCLES    = (CONV_MAX_NS * CLK_MHZ) / 1000;
	localparam int unsigned CONV_CNT_W     = 10;
	localparam int unsigned RESULT_W       = 16;
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned FIFO_AW        = 4;
	localparam logic [15:0] BIPOLAR_FLIP   = 16'h8000;
	// Worst case from a pin change to the state register, in whole cycles
	localparam int unsigned PIN_LAT_CYCLES = 3;
	// Internal timeout leaves room for that latency inside the bound
	localparam int unsigned CONV_LIMIT     = CONV_CYCLES - PIN_LAT_CYCLES;
	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_LIMIT - 1);

	typedef enum logic [2:0] {
		SAPSQ_SHUTDOWN,
		SAPSQ_STANDBY,
		SAPSQ_ACQUIRE,
		SAPSQ_CONVERT,
		SAPSQ_DONE,
		SAPSQ_READ
	} sapsq_state_t;

	// Pins from the host, after synchronising
	typedef struct packed {
		logic cs_n;
		logic read_sel;
		logic upper_byte_sel;
	} sapsq_pins_t;

	// Byte-wide three-state bus, enable low while driving
	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic              oe_n;
	} sapsq_bus_t;
endpackage : sapsq_pkg

// *** rtl/sapsq_top.sv ***
// File holds the sequencer top and its result FIFO.
// Assumes the SAR core hands a raw straight-binary code on sar_code_i
// when sar_valid_i pulses; all host pins are asynchronous to sys_clk_i.
// A pin change reaches the state register at most three edges later:
// two synchroniser stages, then the edge detector feeds the next state.
// The conversion bound counts from the pin, so that latency comes off
// the internal timeout. A core that never answers still ends the
// conversion in time, with the previous result kept for the read.
// Results beyond one per conversion stay queued for later conversions.
// The reference wake time after shutdown is the host's to honour; the
// sequencer does not count it.
`timescale 1ns/10ps

// Result FIFO, flip-flop storage, valid/ready on both sides
// Depth covers a core that answers more than once before a read
module sapsq_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	// Storage and pointers, one register
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
	} sapsq_fifo_st_t;

	sapsq_fifo_st_t s_q;
	sapsq_fifo_st_t s_d;
	logic           full;
	logic           empty;

	// Extra pointer bit tells full from empty
	// Output word is read combinationally; the top registers it on the pop edge
	assign full        = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
	assign empty       = (s_q.wr == s_q.rd);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = s_q.mem[s_q.rd[AW-1:0]];

	// Next state of pointers and storage
	// A write while full is dropped, not stalled: the core has no back-pressure
	always_comb begin
		s_d = s_q;
		if (in_valid_i && !full) begin
			s_d.mem[s_q.wr[AW-1:0]] = in_data_i;
			s_d.wr                  = s_q.wr + 1'b1;
		end
		if (out_ready_i && !empty) begin
			s_d.rd = s_q.rd + 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : sapsq_fifo // sapsq_fifo

// Sequencer top: host strobes in, core start and hold out, byte bus out.
// State walk: shutdown or standby, acquire, convert, done, read, and back
// to standby or shutdown as chosen at the second strobe fall.
// Shutdown and standby differ only in the reference being on; both wait
// for a fall with select low. Done waits for a fall with select high.
module sapsq_top
	import sapsq_pkg::*;
#(
	parameter bit BIPOLAR = 1'b1
) (
	input  wire logic                sys_clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                cs_n_i,
	input  wire logic                read_sel_i,
	input  wire logic                upper_byte_sel_i,
	input  wire logic [RESULT_W-1:0] sar_code_i,
	input  wire logic                sar_valid_i,
	output logic                     sar_start_o,
	output logic                     track_hold_o,
	output logic                     ref_power_o,
	output logic                     eoc_n_o,
	output logic [BYTE_W-1:0]        result_bus_o,
	output logic                     result_bus_oe_n_o
);
	// Whole sequencer state; one comb block fills s_d, one process registers it
	typedef struct packed {
		sapsq_pins_t         meta;
		sapsq_pins_t         pins;
		logic                cs_n_prev;
		sapsq_state_t        state;
		logic                shutdown_sel;
		logic [CONV_CNT_W-1:0] conv_cnt;
		logic                pend;
		logic [RESULT_W-1:0] result;
		logic                start;
		logic                hold;
		logic                ref_on;
		logic                eoc_n;
		sapsq_bus_t          bus;
	} sapsq_st_t;

	// Registered state, its next value, and the glue between them
	sapsq_st_t           s_q;
	sapsq_st_t           s_d;
	logic [1:0]          rst_sync_q;
	logic [1:0]          rst_sync_d;
	logic                rst_n;
	logic                cs_fall;
	logic                cs_rise;
	logic                fifo_out_valid;
	logic                fifo_pop;
	logic [RESULT_W-1:0] fifo_out;
	logic [RESULT_W-1:0] coded;

	// Reset enters at once but leaves through two flops, so no register
	// sees its release near a clock edge; kept apart from the main state
	// because it is the one register cleared by the raw reset pin
	assign rst_sync_d = {rst_sync_q[0], 1'b1};
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= '0;
		end else begin
			rst_sync_q <= rst_sync_d;
		end
	end
	assign rst_n = rst_sync_q[1];

	// Edges from second synchroniser stage only
	// The previous copy resets high, the pin's idle level, so reset gives no edge
	assign cs_fall = s_q.cs_n_prev && !s_q.pins.cs_n;
	assign cs_rise = !s_q.cs_n_prev && s_q.pins.cs_n;
	// Unipolar keeps straight binary, bipolar flips the sign bit
	assign coded   = BIPOLAR ? (sar_code_i ^ BIPOLAR_FLIP) : sar_code_i;

	// Conversion results queue here; popped at most once per conversion, while in the convert state
	sapsq_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(FIFO_DEPTH),
		.AW   (FIFO_AW)
	) u_fifo (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n),
		.in_data_i  (coded),
		.in_valid_i (sar_valid_i),
		.in_ready_o (),
		.out_data_o (fifo_out),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop)
	);
	// Pop only while converting: a result is never taken into a done cycle
	assign fifo_pop = (s_q.state == SAPSQ_CONVERT) && fifo_out_valid;

	// Sequencer next state
	always_comb begin
		s_d           = s_q;
		s_d.meta      = '{cs_n: cs_n_i, read_sel: read_sel_i, upper_byte_sel: upper_byte_sel_i};
		s_d.pins      = s_q.meta;
		s_d.cs_n_prev = s_q.pins.cs_n;
		s_d.start     = 1'b0;
		unique case (s_q.state)
			SAPSQ_SHUTDOWN, SAPSQ_STANDBY: begin
				// Select high at a starting edge: edge is dropped
				// Reference comes up at the fall; the host covers its settling time
				if (cs_fall && !s_q.pins.read_sel) begin
					s_d.state  = SAPSQ_ACQUIRE;
					s_d.ref_on = 1'b1;
					s_d.hold   = 1'b0;
				end
			end
			SAPSQ_ACQUIRE: begin
				// Second fall: sample held, power mode latched for the end
				if (cs_fall) begin
					s_d.hold         = 1'b1;
					s_d.start        = 1'b1;
					s_d.shutdown_sel = s_q.pins.read_sel;
					s_d.conv_cnt     = '0;
					s_d.pend         = 1'b0;
					s_d.state        = SAPSQ_CONVERT;
				end
			end
			SAPSQ_CONVERT: begin
				// Core may stall; the counter bounds the done flag anyway
				// Pop and done share one edge, so the flag never leads the result
				if (fifo_out_valid) begin
					s_d.result = fifo_out;
					s_d.pend   = 1'b1;
				end
				if (s_q.pend || fifo_out_valid || s_q.conv_cnt == CONV_LAST) begin
					s_d.eoc_n = 1'b0;
					s_d.state = SAPSQ_DONE;
					// Standby keeps the reference, shutdown drops it
					s_d.ref_on = !s_q.shutdown_sel;
				end else begin
					s_d.conv_cnt = s_q.conv_cnt + 1'b1;
				end
			end
			SAPSQ_DONE: begin
				// Only a fall with select high reads; a low one is dropped
				if (cs_fall && s_q.pins.read_sel) begin
					s_d.state    = SAPSQ_READ;
					s_d.bus.oe_n = 1'b0;
				end
			end
			SAPSQ_READ: begin
				// Rise ends the read; the mode picked at the second fall decides the rest
				if (cs_rise) begin
					s_d.bus.oe_n = 1'b1;
					s_d.eoc_n    = 1'b1;
					s_d.hold     = 1'b0;
					s_d.state    = s_q.shutdown_sel ? SAPSQ_SHUTDOWN : SAPSQ_STANDBY;
				end
			end
		endcase
		// Byte steering tracks the select pin live while driving
		// Data is registered, so a byte change shows one edge after the select syncs
		s_d.bus.data = s_q.pins.upper_byte_sel ? s_q.result[RESULT_W-1:BYTE_W]
		                                       : s_q.result[BYTE_W-1:0];
		// Bus is never driven outside the read phase
		// Decided on the next state so enable and state change at one edge
		if (s_d.state != SAPSQ_READ) begin
			s_d.bus.oe_n = 1'b1;
		end
	end

	// Sequencer state register
	// Field by field, so a new field cannot slip past the reset values
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q.meta      <= '{cs_n: 1'b1, read_sel: 1'b0, upper_byte_sel: 1'b0};
			s_q.pins      <= '{cs_n: 1'b1, read_sel: 1'b0, upper_byte_sel: 1'b0};
			s_q.cs_n_prev <= 1'b1;
			s_q.state     <= SAPSQ_SHUTDOWN;
			s_q.shutdown_sel <= 1'b1;
			s_q.conv_cnt  <= '0;
			s_q.pend      <= 1'b0;
			s_q.result    <= '0;
			s_q.start     <= 1'b0;
			s_q.hold      <= 1'b0;
			s_q.ref_on    <= 1'b0;
			s_q.eoc_n     <= 1'b1;
			s_q.bus       <= '{data: '0, oe_n: 1'b1};
		end else begin
			s_q.meta      <= s_d.meta;
			s_q.pins      <= s_d.pins;
			s_q.cs_n_prev <= s_d.cs_n_prev;
			s_q.state     <= s_d.state;
			s_q.shutdown_sel <= s_d.shutdown_sel;
			s_q.conv_cnt  <= s_d.conv_cnt;
			s_q.pend      <= s_d.pend;
			s_q.result    <= s_d.result;
			s_q.start     <= s_d.start;
			s_q.hold      <= s_d.hold;
			s_q.ref_on    <= s_d.ref_on;
			s_q.eoc_n     <= s_d.eoc_n;
			s_q.bus       <= s_d.bus;
		end
	end

	// Outputs straight from flip-flops
	// Bus enable and data share one register stage, so they move together
	assign sar_start_o       = s_q.start;
	assign track_hold_o      = s_q.hold;
	assign ref_power_o       = s_q.ref_on;
	assign eoc_n_o           = s_q.eoc_n;
	assign result_bus_o      = s_q.bus.data;
	assign result_bus_oe_n_o = s_q.bus.oe_n;
endmodule : sapsq_top // sapsq_top

// *** verification/sapsq_props.sv ***
// Checker for the sequencer top, bound to it; sees only its ports.
// Assumes the raw reset port, so the internal two-flop release is covered.
`timescale 1ns/10ps
module sapsq_props
	import sapsq_pkg::*;
(
	input wire logic                sys_clk_i,
	input wire logic                rst_n_i,
	input wire logic                cs_n_i,
	input wire logic                read_sel_i,
	input wire logic                upper_byte_sel_i,
	input wire logic [RESULT_W-1:0] sar_code_i,
	input wire logic                sar_valid_i,
	input wire logic                sar_start_o,
	input wire logic                track_hold_o,
	input wire logic                ref_power_o,
	input wire logic                eoc_n_o,
	input wire logic [BYTE_W-1:0]   result_bus_o,
	input wire logic                result_bus_oe_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Bus, flag, hold and reference relations
	a_bus_off_convert: assert property (eoc_n_o |-> result_bus_oe_n_o)
		else $error("bus driven during conversion");
	a_start_with_hold: assert property ($rose(sar_start_o) |-> track_hold_o)
		else $error("conversion began without hold");
	a_ref_at_start: assert property ($rose(sar_start_o) |-> ref_power_o)
		else $error("conversion began with reference off");
	a_done_bound: assert property ($rose(track_hold_o) |-> ##[1:584] !eoc_n_o)
		else $error("conversion overran its time");
	a_drive_needs_done: assert property (!result_bus_oe_n_o |-> !eoc_n_o)
		else $error("bus driven without result");
	a_done_holds: assert property ($fell(eoc_n_o) |-> !eoc_n_o [*4])
		else $error("done flag dropped early");
	a_drive_after_read: assert property ($fell(result_bus_oe_n_o) |-> $past(cs_n_i, 2) == 1'b0)
		else $error("bus driven without read strobe");
	a_release_on_rise: assert property ($rose(cs_n_i) && !result_bus_oe_n_o |-> ##[1:5] result_bus_oe_n_o)
		else $error("bus not released");
	// Main scenarios reached
	c_done: cover property ($fell(eoc_n_o));
	c_high_byte: cover property (!result_bus_oe_n_o && upper_byte_sel_i);
	c_ref_off: cover property ($fell(ref_power_o));
endmodule // sapsq_props

bind sapsq_top sapsq_props u_props (.sys_clk_i, .rst_n_i, .cs_n_i, .read_sel_i,
	.upper_byte_sel_i, .sar_code_i, .sar_valid_i, .sar_start_o, .track_hold_o,
	.ref_power_o, .eoc_n_o, .result_bus_o, .result_bus_oe_n_o);

// *** verification/sapsq_core_model.sv ***
// Behavioural converter core answering each start with one code.
// Assumes the start pulse is one cycle; mute withholds the answer.
`timescale 1ns/10ps
module sapsq_core_model #(
	parameter int DLY = 40
) (
	input  wire logic        sys_clk_i,
	input  wire logic        start_i,
	input  wire logic        mute_i,
	input  wire logic [15:0] code_i,
	output logic             valid_o,
	output logic [15:0]      code_o
);
	int cnt = 0;
	initial valid_o = 1'b0;
	// Answer well inside the conversion time; data inverted outside the pulse
	always @(posedge sys_clk_i) begin
		cnt <= start_i ? DLY : (cnt > 0 ? cnt - 1 : 0);
		valid_o <= (cnt == 1) && !mute_i;
		code_o <= (cnt == 1) ? code_i : ~code_i;
	end
endmodule // sapsq_core_model

// *** verification/sar_adc_parallel_sequencer_bench.sv ***
// Self-checking bench: host strobes driven by hand, core model answers.
// Assumes default bipolar coding and the sync latency of the hand-over.
`timescale 1ns/10ps
module sar_adc_parallel_sequencer_bench;
	import sapsq_pkg::*;
	logic        clk = 0, rst_n = 0, cs_n = 1, sel = 0, hb = 0, mute = 0;
	logic [15:0] code = 16'h0000, sc;
	logic        sv, start, hold, refp, eoc_n, oe_n;
	logic [7:0]  bus;
	int          err_total = 0, comparisons = 0, cyc_n = 0, starts = 0;
	// Stand-in for the reference wake time: the model has no settling, and
	// the full time would outlast the whole run
	localparam int WAKE_WAIT = 64;
	sapsq_top uut (.sys_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .read_sel_i(sel),
		.upper_byte_sel_i(hb), .sar_code_i(sc), .sar_valid_i(sv), .sar_start_o(start),
		.track_hold_o(hold), .ref_power_o(refp), .eoc_n_o(eoc_n), .result_bus_o(bus),
		.result_bus_oe_n_o(oe_n));
	sapsq_core_model core (.sys_clk_i(clk), .start_i(start), .mute_i(mute),
		.code_i(code), .valid_o(sv), .code_o(sc));
	initial forever #4 clk = ~clk;
	// Hang guard and start pulse count
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (start === 1'b1) begin
			starts <= starts + 1;
		end
		if (cyc_n == 6000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Pins change just after an edge, then sync latency passes
	task automatic strobe(input logic c, input logic s);
		cs_n = c;
		sel = s;
		step(6);
	endtask
	// Start strobe with select high is refused while powered down
	task automatic t_refused();
		strobe(1'b0, 1'b1);
		chk(16'(refp), 16'h0000);
		chk(16'(hold), 16'h0000);
		strobe(1'b1, 1'b1);
	endtask
	// Acquire, convert, read both bytes, release
	task automatic t_cycle(input logic mode, input logic [15:0] val);
		logic [15:0] exp;
		logic        wake;
		int          i;
		int          n_start;
		exp = val ^ 16'h8000;
		wake = !refp;
		n_start = starts;
		strobe(1'b0, 1'b0);
		chk(16'(refp), 16'h0001);
		strobe(1'b1, 1'b0);
		if (wake) step(WAKE_WAIT);
		strobe(1'b0, mode);
		// Input switched right after the sample is held
		code = val;
		chk(16'(hold), 16'h0001);
		chk(16'(oe_n), 16'h0001);
		i = 0;
		while (i < 600 && eoc_n !== 1'b0) begin
			step(1);
			i++;
		end
		chk(16'(eoc_n), 16'h0000);
		// Cycles from the convert strobe pin to the done flag
		chk(16'(6 + i <= CONV_CYCLES), 16'h0001);
		chk(16'(starts - n_start), 16'h0001);
		step(2);
		chk(16'(refp), 16'(!mode));
		strobe(1'b1, 1'b1);
		strobe(1'b0, 1'b1);
		chk(16'(oe_n), 16'h0000);
		chk({8'h00, bus}, {8'h00, exp[7:0]});
		hb = 1'b1;
		step(6);
		chk({8'h00, bus}, {8'h00, exp[15:8]});
		hb = 1'b0;
		strobe(1'b1, 1'b1);
		chk(16'(oe_n), 16'h0001);
		chk(16'(eoc_n), 16'h0001);
	endtask
	// Main sequence
	initial begin
		step(16);
		rst_n = 1'b1;
		step(6);
		t_refused();
		t_cycle(1'b0, 16'h1234);
		t_cycle(1'b1, 16'hABCD);
		t_cycle(1'b0, 16'h0FF0);
		mute = 1'b1;
		t_cycle(1'b0, 16'h0FF0);
		report_and_stop();
	end
endmodule // sar_adc_parallel_sequencer_bench
